// *** rtl/tc_accept_pkg.sv ***
package tc_accept_pkg;

    // Header layout, first transmitted bit is the MSB of hdr
    typedef struct packed {
        logic [1:0] version;
        logic       bypass;
        logic       control;
        logic [1:0] resv_a;
        logic [9:0] scid;
        logic [5:0] vcid;
        logic [1:0] resv_b;
        logic [7:0] length;
        logic [7:0] seq;
    } tc_header_t;

    // Clean frame: header and first three data octets
    typedef struct packed {
        tc_header_t hdr;
        logic [7:0] data0;
        logic [7:0] data1;
        logic [7:0] data2;
        logic [2:0] channel;
    } tc_frame_t;

    // Periodic acceptance report
    typedef struct packed {
        logic [7:0] expected_seq;
        logic       lockout;
        logic       wait_flag;
        logic       retransmit;
        logic [1:0] bypass_count;
    } clcw_report_t;

    typedef enum logic [1:0] {
        ST_OPEN,
        ST_WAIT,
        ST_LOCKOUT
    } farm_state_t;

    // Control command encodings
    localparam logic [7:0] CMD_UNLOCK     = 8'h00;
    localparam logic [7:0] CMD_SETSEQ_0   = 8'h82;
    localparam logic [7:0] CMD_SETSEQ_1   = 8'h00;
    // Length field is total octets minus one: 5 header + data + 2 check
    localparam logic [7:0] LEN_UNLOCK     = 8'h07;
    localparam logic [7:0] LEN_SETSEQ     = 8'h09;
    localparam logic [7:0] SEQ_ZERO       = 8'h00;

    // APB map
    localparam logic [11:0] ADDR_CFG      = 12'h000;
    localparam logic [11:0] ADDR_WIN      = 12'h004;
    localparam logic [11:0] ADDR_STATUS   = 12'h008;

    // CFG field positions
    localparam int CFG_VER_LSB   = 0;
    localparam int CFG_RSA_LSB   = 2;
    localparam int CFG_RSB_LSB   = 4;
    localparam int CFG_VCID_LSB  = 6;
    localparam int CFG_SCID_LSB  = 12;
    // WIN field positions
    localparam int WIN_PW_LSB    = 0;
    localparam int WIN_NW_LSB    = 8;
    // STATUS field positions
    localparam int ST_VR_LSB     = 0;
    localparam int ST_STATE_LSB  = 8;
    localparam int ST_LOCK_BIT   = 10;
    localparam int ST_WAIT_BIT   = 11;
    localparam int ST_RETX_BIT   = 12;
    localparam int ST_BCNT_LSB   = 13;
    localparam int ST_FULL_BIT   = 15;
    localparam int ST_IDX_BIT    = 16;
    localparam int ST_CHAN_LSB   = 17;

    // Reset values of the configuration words
    localparam logic [1:0] RST_VERSION = 2'h0;
    localparam logic [1:0] RST_RESV    = 2'h0;
    localparam logic [9:0] RST_SCID    = 10'h000;
    localparam logic [5:0] RST_VCID    = 6'h00;
    localparam logic [7:0] RST_PW      = 8'h0a;
    localparam logic [7:0] RST_NW      = 8'h0a;
    localparam logic [7:0] RST_VR      = 8'h00;

endpackage

// *** rtl/tc_frame_acceptance.sv ***
// Implementation choices: the placing of the registers and the APB interface to the registers.
`timescale 1ns/10ps
// Summary of operation
// [R1] Version, reserved fields and spacecraft ID match configuration.
// [R2] Channel ID LSB inverted when the invert input is 1.
// [R3] Bypass 0, control 1 fails validation.
// [R4] Control frames carry unlock or set-sequence, else fail.
// [R5] Control and bypass data frames need sequence zero.
// [R6] Legal frames go to the machine; others are dropped.
// [R7] States Open, Wait, Lockout; flags follow state.
// [R8] Two-bit wrapping counter counts bypass and control frames.
// [R9] Sequenced frame outside both windows is out of window.
// [R10] Out-of-window frame is discarded and forces Lockout.
// [R11] Frame ahead inside positive window sets retransmit.
// [R12] Negative-window frame is discarded, nothing else.
// [R13] Accepted sequenced frame buffered only when buffer empty.
// [R14] Bypass data always buffered, aborting old data.
// [R15] Bypass data moves Wait to Open.
// [R16] Lockout drops sequenced frames, takes bypass data.
// [R17] Unlock counts, clears retransmit and opens.
// [R18] Set-sequence loads expected number, opens; Lockout only counts.
// [R19] Release clears wait: Wait to Open, Lockout stays.
// [R20] Delivered expected-sequence frame clears retransmit.
// [R21] Report shows expected number, flags, counter.
// [R22] Outputs show buffer index and buffered channel.
// [R23] Unlock is 00h; set-sequence is 82h, 00h, number.
// [R24] Flags: 00 sequenced, 01 illegal, 10 bypass data, 11 control.
// [R25] Header widths in order: 2,1,1,2,10,6,2,8,8.
// [R26] Expected frame delivered when buffer free; numbers wrap mod 256.
// [R27] Full buffer refuses expected frame: retransmit, Open to Wait.
module tc_frame_acceptance #(
    parameter logic [7:0] POS_WIDTH_DEFAULT = tc_accept_pkg::RST_PW,
    parameter logic [7:0] NEG_WIDTH_DEFAULT = tc_accept_pkg::RST_NW
) (
    input  wire logic                     pclk,
    input  wire logic                     presetn,
    input  wire logic                     psel,
    input  wire logic                     penable,
    input  wire logic                     pwrite,
    input  wire logic [11:0]              paddr,
    input  wire logic [31:0]              pwdata,
    output logic      [31:0]              prdata,
    output logic                          pready,
    output logic                          pslverr,
    input  wire logic                     channel_id_lsb_invert,
    input  wire tc_accept_pkg::tc_frame_t frame_in,
    input  wire logic                     frame_strobe,
    input  wire logic                     buffer_release,
    input  wire logic                     clcw_report_time,
    output tc_accept_pkg::clcw_report_t   clcw_out,
    output logic                          clcw_valid,
    output logic                          new_data_out,
    output logic                          abort_out,
    output logic                          frame_rejected,
    output logic [7:0]                    buffered_seq_out,
    output logic                          backend_buffer_index_out,
    output logic [2:0]                    buffered_channel_number_out
);
    import tc_accept_pkg::*;

    ////////////////////////////////////////
    // Configuration and state storage

    logic [1:0]   cfg_version_ff;
    logic [1:0]   cfg_resv_a_ff;
    logic [1:0]   cfg_resv_b_ff;
    logic [5:0]   cfg_vcid_ff;
    logic [9:0]   cfg_scid_ff;
    logic [7:0]   pos_window_width_ff;
    logic [7:0]   negative_window_width_ff;
    farm_state_t  state_ff;
    farm_state_t  nxt_state;
    logic         retx_ff;
    logic         nxt_retx;
    logic [1:0]   bypass_frame_counter_ff;
    logic [1:0]   nxt_bypass_cnt;
    logic [7:0]   vr_ff;
    logic [7:0]   nxt_vr;
    logic         buf_full_ff;
    logic         nxt_buf_full;
    logic         deliver;
    logic         abort_req;
    logic         reject;

    ////////////////////////////////////////
    // Legal frame validation, combinational so a frame acts in its own cycle

    logic [5:0] exp_vcid;
    logic       hdr_ok;
    logic       flags_ok;
    logic       is_ad;
    logic       is_bd;
    logic       is_bc;
    logic       cmd_unlock;
    logic       cmd_setseq;
    logic       cmd_ok;
    logic       seq_ok;
    logic       legal;

    // Redundant decoder pairs differ only in the channel ID LSB
    assign exp_vcid = {cfg_vcid_ff[5:1], cfg_vcid_ff[0] ^ channel_id_lsb_invert}; // [R2]

    assign hdr_ok = (frame_in.hdr.version == cfg_version_ff)
                  && (frame_in.hdr.resv_a == cfg_resv_a_ff)
                  && (frame_in.hdr.resv_b == cfg_resv_b_ff)
                  && (frame_in.hdr.scid == cfg_scid_ff)  // [R1] [R25]
                  && (frame_in.hdr.vcid == exp_vcid);    // [R2]

    // Flag decode
    assign is_ad    = !frame_in.hdr.bypass && !frame_in.hdr.control; // [R24]
    assign is_bd    =  frame_in.hdr.bypass && !frame_in.hdr.control; // [R24]
    assign is_bc    =  frame_in.hdr.bypass &&  frame_in.hdr.control; // [R24]
    assign flags_ok = is_ad || is_bd || is_bc;                       // [R3]

    // Length checked too, so trailing octets fail
    assign cmd_unlock = (frame_in.hdr.length == LEN_UNLOCK)
                      && (frame_in.data0 == CMD_UNLOCK); // [R23]
    assign cmd_setseq = (frame_in.hdr.length == LEN_SETSEQ)
                      && (frame_in.data0 == CMD_SETSEQ_0)
                      && (frame_in.data1 == CMD_SETSEQ_1); // [R23]
    assign cmd_ok     = !is_bc || cmd_unlock || cmd_setseq; // [R4]
    assign seq_ok     = is_ad || (frame_in.hdr.seq == SEQ_ZERO); // [R5]

    assign legal = frame_strobe && hdr_ok && flags_ok && cmd_ok && seq_ok; // [R6]

    ////////////////////////////////////////
    // Sliding window classification, all differences modulo 256

    logic [7:0] ahead;
    logic [7:0] behind;
    logic       in_expected;
    logic       in_positive;
    logic       in_negative;

    assign ahead  = frame_in.hdr.seq - vr_ff;  // [R26]
    assign behind = vr_ff - frame_in.hdr.seq;  // [R26]
    assign in_expected = (ahead == 8'h00);
    // Positive part: PW-1 numbers above expected
    assign in_positive = !in_expected && (ahead < pos_window_width_ff); // [R11]
    // Checked after positive, so overlaps favour positive
    assign in_negative = !in_expected && !in_positive
                       && (behind <= negative_window_width_ff); // [R12]
    // Anything else lies in the lockout area

    ////////////////////////////////////////
    // Acceptance machine next-state logic

    always_comb begin
        nxt_state      = state_ff;
        nxt_retx       = retx_ff;
        nxt_bypass_cnt = bypass_frame_counter_ff;
        nxt_vr         = vr_ff;
        nxt_buf_full   = buf_full_ff;
        deliver        = 1'b0;
        abort_req      = 1'b0;
        reject         = frame_strobe && !legal; // [R6]
        // Release frees the buffer before a same-cycle frame looks
        if (buffer_release) begin
            nxt_buf_full = 1'b0;
            if (state_ff == ST_WAIT) begin
                nxt_state = ST_OPEN; // [R19]
            end
        end
        if (legal) begin
            if (is_ad) begin
                if (in_expected) begin
                    if (state_ff == ST_LOCKOUT) begin
                        nxt_state = ST_LOCKOUT; // [R16]
                    end else if (!nxt_buf_full) begin
                        deliver      = 1'b1; // [R13] [R26]
                        nxt_buf_full = 1'b1;
                        nxt_vr       = vr_ff + 8'h01; // [R26]
                        nxt_retx     = 1'b0; // [R20]
                    end else begin
                        nxt_retx  = 1'b1; // [R27]
                        nxt_state = ST_WAIT; // [R27] [R13]
                    end
                end else if (in_positive) begin
                    if (state_ff != ST_LOCKOUT) begin
                        nxt_retx = 1'b1; // [R11]
                    end
                end else if (!in_negative) begin
                    nxt_state = ST_LOCKOUT; // [R9] [R10]
                end
            end else if (is_bd) begin
                deliver        = 1'b1; // [R14]
                abort_req      = nxt_buf_full; // [R14]
                nxt_buf_full   = 1'b1;
                nxt_bypass_cnt = bypass_frame_counter_ff + 2'd1; // [R8]
                if (state_ff == ST_WAIT) begin
                    nxt_state = ST_OPEN; // [R15]
                end
            end else begin
                nxt_bypass_cnt = bypass_frame_counter_ff + 2'd1; // [R8]
                if (cmd_unlock) begin
                    nxt_retx  = 1'b0; // [R17]
                    nxt_state = ST_OPEN; // [R17]
                end else if (state_ff != ST_LOCKOUT) begin
                    nxt_retx  = 1'b0; // [R18]
                    nxt_vr    = frame_in.data2; // [R18]
                    nxt_state = ST_OPEN; // [R18]
                end
            end
        end
    end

    ////////////////////////////////////////
    // Acceptance machine state

    // Flags decode from state, so they never disagree
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_ff <= ST_OPEN;
        end else begin
            state_ff <= nxt_state; // [R7]
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            retx_ff                 <= 1'b0;
            bypass_frame_counter_ff <= 2'd0;
        end else begin
            retx_ff                 <= nxt_retx;
            bypass_frame_counter_ff <= nxt_bypass_cnt; // [R8]
        end
    end

    // Expected sequence number
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            vr_ff <= RST_VR;
        end else begin
            vr_ff <= nxt_vr;
        end
    end

    ////////////////////////////////////////
    // Back-end buffer handover

    // Index toggles per delivery so the reader tells buffers apart
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            buf_full_ff                 <= 1'b0;
            backend_buffer_index_out    <= 1'b0;
            buffered_channel_number_out <= 3'd0;
            buffered_seq_out            <= 8'h00;
        end else begin
            buf_full_ff <= nxt_buf_full;
            if (deliver) begin
                backend_buffer_index_out    <= !backend_buffer_index_out; // [R22]
                buffered_channel_number_out <= frame_in.channel;          // [R22]
                buffered_seq_out            <= frame_in.hdr.seq;
            end
        end
    end

    // One-cycle event pulses to the layer above
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            new_data_out   <= 1'b0;
            abort_out      <= 1'b0;
            frame_rejected <= 1'b0;
        end else begin
            new_data_out   <= deliver;   // [R14]
            abort_out      <= abort_req; // [R14]
            frame_rejected <= reject;    // [R6]
        end
    end

    ////////////////////////////////////////
    // Periodic report, a snapshot only

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            clcw_out   <= '0;
            clcw_valid <= 1'b0;
        end else begin
            clcw_valid <= clcw_report_time; // [R21]
            if (clcw_report_time) begin
                clcw_out.expected_seq <= vr_ff;                      // [R21]
                clcw_out.lockout      <= (state_ff == ST_LOCKOUT);   // [R7] [R21]
                clcw_out.wait_flag    <= (state_ff == ST_WAIT);      // [R7] [R21]
                clcw_out.retransmit   <= retx_ff;                    // [R21]
                clcw_out.bypass_count <= bypass_frame_counter_ff;    // [R21]
            end
        end
    end

    ////////////////////////////////////////
    // APB slave

    logic        access;
    logic        hit_cfg;
    logic        hit_win;
    logic        hit_status;
    logic [31:0] rd_mux;

    assign access     = psel && penable && !pready;
    assign hit_cfg    = (paddr == ADDR_CFG);
    assign hit_win    = (paddr == ADDR_WIN);
    assign hit_status = (paddr == ADDR_STATUS);

    always_comb begin
        rd_mux = 32'h0000_0000;
        if (hit_cfg) begin
            rd_mux[CFG_VER_LSB +: 2]  = cfg_version_ff;
            rd_mux[CFG_RSA_LSB +: 2]  = cfg_resv_a_ff;
            rd_mux[CFG_RSB_LSB +: 2]  = cfg_resv_b_ff;
            rd_mux[CFG_VCID_LSB +: 6] = cfg_vcid_ff;
            rd_mux[CFG_SCID_LSB +: 10] = cfg_scid_ff;
        end else if (hit_win) begin
            rd_mux[WIN_PW_LSB +: 8] = pos_window_width_ff;
            rd_mux[WIN_NW_LSB +: 8] = negative_window_width_ff;
        end else if (hit_status) begin
            rd_mux[ST_VR_LSB +: 8]    = vr_ff;
            rd_mux[ST_STATE_LSB +: 2] = state_ff;
            rd_mux[ST_LOCK_BIT]       = (state_ff == ST_LOCKOUT);
            rd_mux[ST_WAIT_BIT]       = (state_ff == ST_WAIT);
            rd_mux[ST_RETX_BIT]       = retx_ff;
            rd_mux[ST_BCNT_LSB +: 2]  = bypass_frame_counter_ff;
            rd_mux[ST_FULL_BIT]       = buf_full_ff;
            rd_mux[ST_IDX_BIT]        = backend_buffer_index_out;
            rd_mux[ST_CHAN_LSB +: 3]  = buffered_channel_number_out;
        end
    end

    // One wait state; unmapped addresses error out
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
        end else begin
            pready  <= access;
            pslverr <= access && !(hit_cfg || hit_win || hit_status);
            if (access && !pwrite) begin
                prdata <= rd_mux;
            end
        end
    end

    // Writes land on the edge where pready is high
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cfg_version_ff           <= RST_VERSION;
            cfg_resv_a_ff            <= RST_RESV;
            cfg_resv_b_ff            <= RST_RESV;
            cfg_vcid_ff              <= RST_VCID;
            cfg_scid_ff              <= RST_SCID;
            pos_window_width_ff      <= POS_WIDTH_DEFAULT;
            negative_window_width_ff <= NEG_WIDTH_DEFAULT;
        end else if (psel && penable && pready && pwrite) begin
            if (hit_cfg) begin
                cfg_version_ff <= pwdata[CFG_VER_LSB +: 2];
                cfg_resv_a_ff  <= pwdata[CFG_RSA_LSB +: 2];
                cfg_resv_b_ff  <= pwdata[CFG_RSB_LSB +: 2];
                cfg_vcid_ff    <= pwdata[CFG_VCID_LSB +: 6];
                cfg_scid_ff    <= pwdata[CFG_SCID_LSB +: 10];
            end
            if (hit_win) begin
                pos_window_width_ff      <= pwdata[WIN_PW_LSB +: 8];
                negative_window_width_ff <= pwdata[WIN_NW_LSB +: 8];
            end
        end
    end

endmodule

// *** sim/tc_frame_acceptance_sva.sv ***
`timescale 1ns/10ps
module tc_frame_acceptance_sva (
    input wire logic                        pclk,
    input wire logic                        presetn,
    input wire tc_accept_pkg::tc_frame_t    frame_in,
    input wire logic                        frame_strobe,
    input wire logic                        clcw_report_time,
    input wire logic                        clcw_valid,
    input wire logic                        new_data_out,
    input wire logic                        abort_out,
    input wire logic                        frame_rejected,
    input wire logic                        backend_buffer_index_out,
    input wire logic [2:0]                  buffered_channel_number_out
);
    import tc_accept_pkg::*;

    // One clock domain; nothing is judged while reset is low
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);

    ////////////////////////////////////////
    property p_rej_cause; frame_rejected |-> $past(frame_strobe); endproperty
    a_rej_cause: assert property (p_rej_cause) else $error("reject without frame");
    property p_nd_cause; new_data_out |-> $past(frame_strobe) && !frame_rejected; endproperty
    a_nd_cause: assert property (p_nd_cause) else $error("delivery without legal frame");
    property p_abort; abort_out |-> new_data_out; endproperty
    a_abort: assert property (p_abort) else $error("abort without new data");
    // Index flips exactly on deliveries, never on its own
    property p_idx; new_data_out == $changed(backend_buffer_index_out); endproperty
    a_idx: assert property (p_idx) else $error("buffer index out of step");
    property p_chan;
        new_data_out |-> buffered_channel_number_out == $past(frame_in.channel);
    endproperty
    a_chan: assert property (p_chan) else $error("wrong buffered channel");
    property p_illegal;
        frame_strobe && !frame_in.hdr.bypass && frame_in.hdr.control |=> frame_rejected;
    endproperty
    a_illegal: assert property (p_illegal) else $error("illegal flags accepted");
    property p_bd_seq;
        frame_strobe && frame_in.hdr.bypass && frame_in.hdr.seq != 8'h00 |=> frame_rejected;
    endproperty
    a_bd_seq: assert property (p_bd_seq) else $error("nonzero sequence accepted");
    property p_report; clcw_report_time |=> clcw_valid; endproperty
    a_report: assert property (p_report) else $error("report missing");
endmodule

bind tc_frame_acceptance tc_frame_acceptance_sva i_tc_frame_acceptance_sva (
    .pclk, .presetn, .frame_in, .frame_strobe, .clcw_report_time, .clcw_valid,
    .new_data_out, .abort_out, .frame_rejected, .backend_buffer_index_out,
    .buffered_channel_number_out);

// *** sim/tc_higher_layer.sv ***
`timescale 1ns/10ps
module tc_higher_layer (
    input  wire logic       pclk,
    input  wire logic       presetn,
    input  wire logic       new_data_out,
    input  wire logic       hold,
    input  wire logic [3:0] lag,
    output logic            buffer_release
);
    logic       busy_ff;
    logic [3:0] left_ff;

    // Reads the buffer out lag cycles after a delivery; hold models a stalled reader
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            {busy_ff, left_ff, buffer_release} <= '0;
        end else begin
            // No release in a delivery cycle, or fresh data would be freed unread
            buffer_release <= busy_ff && !hold && left_ff == 4'h0 && !new_data_out;
            if (new_data_out) begin
                {busy_ff, left_ff} <= {1'b1, lag};
            end else if (busy_ff && !hold) begin
                busy_ff <= left_ff != 4'h0;
                left_ff <= left_ff - 4'h1;
            end
        end
    end
endmodule

// *** sim/tb.sv ***
`timescale 1ns/10ps
module tb;
    import tc_accept_pkg::*;
    logic         pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, inv = 0;
    logic         strobe = 0, rep = 0, hold = 1, perr, pready, pslverr, rel, cv, nd, ab, rj;
    logic         idx, m_retx, m_full, m_idx, e_nd, e_ab, e_rj, e_cv, ok, unl, sst;
    logic [11:0]  paddr = 12'h000;
    logic [31:0]  pwdata = 32'h0000_0000, prdata, rdata, seed = 32'h0000_b3a8;
    logic [21:0]  cfg = 22'h00_0000;
    logic [7:0]   bseq, m_vr, m_bseq, ah;
    logic [3:0]   lag = 4'h0;
    logic [2:0]   bchan, m_chan;
    logic [1:0]   m_st, m_bc;
    logic [12:0]  e_rep;
    tc_frame_t    fr = '0;
    tc_header_t   h;
    clcw_report_t clcw;
    int           bad_count = 0, compares = 0;

    always #25 pclk = ~pclk;

    tc_frame_acceptance i_tc_frame_acceptance (
        .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
        .channel_id_lsb_invert(inv), .frame_in(fr), .frame_strobe(strobe),
        .buffer_release(rel), .clcw_report_time(rep), .clcw_out(clcw), .clcw_valid(cv),
        .new_data_out(nd), .abort_out(ab), .frame_rejected(rj), .buffered_seq_out(bseq),
        .backend_buffer_index_out(idx), .buffered_channel_number_out(bchan));
    tc_higher_layer i_tc_higher_layer (.pclk, .presetn, .new_data_out(nd), .hold, .lag,
        .buffer_release(rel));

    ////////////////////////////////////////
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    // Header fields a legal frame carries
    function automatic logic [21:0] legal(input logic iv);
        return {cfg[1:0], cfg[3:2], cfg[5:4], cfg[21:12], cfg[11:6] ^ {5'h00, iv}};
    endfunction

    task automatic chk(input string what, input logic [39:0] exp, input logic [39:0] got);
        compares++;
        if (got !== exp) begin
            bad_count++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic finish_test();
        if (bad_count == 0 && compares > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    // Setup, access, wait for pready; only the watchdog ends a hang
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        {psel, pwrite, paddr, pwdata} <= {1'b1, wr, a, d};
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        {rdata, perr} = {prdata, pslverr};
        {psel, penable} <= 2'b00;
    endtask

    task automatic deliver(input logic sequenced);
        {e_nd, e_ab, m_full, m_idx} = {1'b1, m_full, 1'b1, !m_idx};
        {m_chan, m_bseq} = {fr.channel, fr.hdr.seq};
        if (sequenced) {m_vr, m_retx} = {m_vr + 8'd1, 1'b0};
        else if (m_st == 2'd1) m_st = 2'd0;
    endtask

    // One frame slot; now and then a header bit flipped
    task automatic send();
        logic [31:0] r;
        tc_frame_t   f;
        r = rnd();
        f = 67'({rnd(), rnd(), rnd()});
        {f.hdr.version, f.hdr.resv_a, f.hdr.resv_b, f.hdr.scid, f.hdr.vcid}
            = legal(r[0]) ^ (r[5:3] == 3'd0 ? 22'h1 << (r[10:6] % 5'd22) : 22'h0);
        case (r[13:11])
            3'd3: {f.hdr.bypass, f.hdr.control, f.hdr.seq} = {2'b10, 8'h00};
            3'd4: {f.hdr.bypass, f.hdr.control} = 2'b10;
            3'd5: {f.hdr.bypass, f.hdr.control, f.hdr.seq, f.hdr.length, f.data0}
                = {2'b11, 8'h00, 8'h07, 8'h00};
            3'd6: {f.hdr.bypass, f.hdr.control, f.hdr.seq, f.hdr.length, f.data0, f.data1}
                = {2'b11, 8'h00, 8'h09, 8'h82, 8'h00};
            3'd7: {f.hdr.bypass, f.hdr.control} = 2'b01;
            default: {f.hdr.bypass, f.hdr.control, f.hdr.seq}
                = {2'b00, r[21] ? m_vr : m_vr + {{3{r[20]}}, r[20:16]}};
        endcase
        if (r[23:22] == 2'd0) f.hdr.length = r[31:24];
        {fr, inv, strobe, rep} <= {f, r[0], r[15:14] != 2'd0, r[26:24] == 3'd0};
        @(posedge pclk);
    endtask

    ////////////////////////////////////////
    // Reference: check last outputs, then step
    always @(posedge pclk) begin
        if (!presetn) begin
            {m_st, m_bc, m_vr, m_retx, m_full, m_idx, m_chan, m_bseq} = '0;
            {e_nd, e_ab, e_rj, e_cv} = '0;
        end else begin
            chk("new_data", e_nd, nd);
            chk("abort", e_ab, ab);
            chk("rejected", e_rj, rj);
            chk("report_valid", e_cv, cv);
            chk("buffer", {m_bseq, m_chan, m_idx}, {bseq, bchan, idx});
            if (e_cv) chk("report", e_rep, clcw);
            {e_nd, e_ab, e_rj, e_cv} = {3'b000, rep};
            e_rep = {m_vr, m_st == 2'd2, m_st == 2'd1, m_retx, m_bc};
            if (rel) {m_full, m_st} = {1'b0, m_st == 2'd1 ? 2'd0 : m_st};
            h = fr.hdr;
            unl = fr.data0 == 8'h00 && h.length == 8'h07;
            sst = fr.data0 == 8'h82 && fr.data1 == 8'h00 && h.length == 8'h09;
            ok = {h.version, h.resv_a, h.resv_b, h.scid, h.vcid} == legal(inv);
            ok = ok && (h.bypass || !h.control) && (!h.bypass || h.seq == 8'h00);
            ok = ok && (!h.control || unl || sst);
            if (strobe && !ok) e_rj = 1'b1;
            else if (strobe && h.bypass) begin
                m_bc = m_bc + 2'd1;
                if (!h.control) deliver(1'b0);
                else if (unl) {m_st, m_retx} = 3'b000;
                else if (m_st != 2'd2) {m_vr, m_st, m_retx} = {fr.data2, 3'b000};
            end else if (strobe && m_st != 2'd2) begin
                ah = h.seq - m_vr;
                if (ah == 8'd0 && !m_full) deliver(1'b1);
                else if (ah == 8'd0) {m_st, m_retx} = 3'b011;
                else if (ah < RST_PW) m_retx = 1'b1;
                else if (8'(m_vr - h.seq) > RST_NW) m_st = 2'd2;
            end
        end
    end

    initial begin
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, ADDR_WIN, 32'h0000_0000);
        chk("win_reset", {RST_NW, RST_PW}, rdata);
        apb(1'b0, 12'h00c, 32'h0000_0000);
        chk("unmapped", 33'h1_0000_0000, {perr, rdata});
        // Odd phases stall the reader so the buffer stays full
        for (int ph = 0; ph < 8; ph++) begin
            {hold, lag} <= {ph[0], 4'(rnd())};
            repeat (300) send();
            {strobe, rep, hold} <= 3'b001;
            repeat (4) @(posedge pclk);
            apb(1'b1, ADDR_STATUS, 32'hffff_ffff);
            apb(1'b0, ADDR_STATUS, 32'h0000_0000);
            chk("status", {m_chan, m_idx, m_full, m_bc, m_retx, m_st == 2'd1, m_st == 2'd2,
                m_st, m_vr}, rdata);
            cfg = 22'(rnd());
            apb(1'b1, ADDR_CFG, {10'h000, cfg});
        end
        finish_test();
    end

    // About 2540 cycles are needed; 20000 means a hang
    initial begin
        #1000000;
        bad_count++;
        finish_test();
    end
endmodule
